// ---- logic/fphc_defs.svh ----
`ifndef FPHC_DEFS_SVH
`define FPHC_DEFS_SVH

// register byte offsets
`define FPHC_CTRL_OFS 12'h000
`define FPHC_STATUS_OFS 12'h004
`define FPHC_STEPS_OFS 12'h008

// control field positions and reset value
`define FPHC_CTRL_FETCH_EN 0
`define FPHC_CTRL_SW_RUN 1
`define FPHC_CTRL_SW_STEP 2
`define FPHC_CTRL_RESET 32'h0000_0001

// status field positions
`define FPHC_ST_HALT 0
`define FPHC_ST_STEP 1
`define FPHC_ST_READY 2
`define FPHC_ST_STAGE_A 3
`define FPHC_ST_STAGE_B 4
`define FPHC_ST_SLOW 5

// timing
`define FPHC_CLK_KHZ 200000
`define FPHC_SLOW_PERIOD_MS 786
`define FPHC_SLOW_CYCLES (`FPHC_SLOW_PERIOD_MS * `FPHC_CLK_KHZ)
`define FPHC_PANEL_PERIOD_US 1000
`define FPHC_PANEL_CYCLES (`FPHC_PANEL_PERIOD_US * `FPHC_CLK_KHZ / 1000)

`endif

// ---- logic/fphc_divider.sv ----
`timescale 1ns/100ps
module fphc_divider #(
  parameter int unsigned SLOW_CYCLES = 157200000,
  parameter int unsigned PANEL_CYCLES = 200000
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // one-cycle ticks
  output logic slow_tick,
  output logic panel_tick
);
  import fphc_pkg::*;

  fphc_div_t s_r;
  fphc_div_t s_nxt;

  if (SLOW_CYCLES < 2 || PANEL_CYCLES < 2) begin : g_bad_period
    $error("fphc_divider periods must be at least 2 cycles");
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.slow_tick = 1'b0;
    s_nxt.panel_tick = 1'b0;
    if (s_r.slow_cnt == SLOW_CYCLES - 1) begin
      s_nxt.slow_cnt = 32'h0000_0000;
      s_nxt.slow_tick = 1'b1;
    end else begin
      s_nxt.slow_cnt = s_r.slow_cnt + 32'h0000_0001;
    end
    if (s_r.panel_cnt == PANEL_CYCLES - 1) begin
      s_nxt.panel_cnt = 32'h0000_0000;
      s_nxt.panel_tick = 1'b1;
    end else begin
      s_nxt.panel_cnt = s_r.panel_cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign slow_tick = s_r.slow_tick;
  assign panel_tick = s_r.panel_tick;
endmodule

// ---- logic/fphc_pkg.sv ----
package fphc_pkg;

  typedef struct packed {
    logic stage_a;
    logic stage_b;
    logic halt;
    logic step;
    logic coin_d;
    logic run_d;
    logic step_d;
    logic fetch_en;
    logic [15:0] steps;
    logic [31:0] prdata;
    logic pslverr;
  } fphc_state_t;

  typedef struct packed {
    logic [31:0] slow_cnt;
    logic [31:0] panel_cnt;
    logic slow_tick;
    logic panel_tick;
  } fphc_div_t;

endpackage

// ---- logic/fphc_run_halt.sv ----
// Added by the designer: register access over APB and the register addresses.
`timescale 1ns/100ps
`include "fphc_defs.svh"
module fphc_run_halt #(
  parameter int unsigned SLOW_CYCLES = `FPHC_SLOW_CYCLES,
  parameter int unsigned PANEL_CYCLES = `FPHC_PANEL_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // panel switches, asynchronous levels
  input wire logic stop_switch,
  input wire logic run_switch,
  input wire logic step_switch,
  input wire logic slow_switch,
  // processor bus status, asynchronous
  input wire logic bus_cycle_sync,
  input wire logic status_latch_strobe_n,
  input wire logic fetch_status_bit,
  // control outputs
  output logic panel_ready,
  output logic run_n,
  output logic switch_enable_buffer_n
);
  import fphc_pkg::*;

  fphc_state_t s_r;
  fphc_state_t s_nxt;

  logic [6:0] pins_s;
  logic stop_s;
  logic run_s;
  logic step_s;
  logic slow_s;
  logic sync_s;
  logic strobe_s;
  logic fetch_s;
  logic slow_tick;
  logic panel_tick;
  logic halt_qualify_gate;
  logic qual_pulse;
  logic run_edge;
  logic step_edge;
  logic step_set;
  logic halt_set;
  logic wr_acc;
  logic setup;
  logic [31:0] ctrl_rd;
  logic [31:0] status_rd;

  // both dividers need at least two cycles per period
  if (SLOW_CYCLES < 2 || PANEL_CYCLES < 2) begin : g_bad_period
    $error("fphc_run_halt periods must be at least 2 cycles");
  end

  fphc_sync2 #(
    .WIDTH(7)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({stop_switch, run_switch, step_switch, slow_switch,
      bus_cycle_sync, status_latch_strobe_n, fetch_status_bit}),
    .sync_out(pins_s)
  );

  fphc_divider #(
    .SLOW_CYCLES(SLOW_CYCLES),
    .PANEL_CYCLES(PANEL_CYCLES)
  ) u_div (
    .pclk(pclk),
    .presetn(presetn),
    .slow_tick(slow_tick),
    .panel_tick(panel_tick)
  );

  assign stop_s = pins_s[6];
  assign run_s = pins_s[5];
  assign step_s = pins_s[4];
  assign slow_s = pins_s[3];
  assign sync_s = pins_s[2];
  assign strobe_s = ~pins_s[1];
  assign fetch_s = pins_s[0];

  // with fetch qualification off the gate fires on every machine cycle
  assign halt_qualify_gate = sync_s & strobe_s
    & (fetch_s | ~s_r.fetch_en);
  // edge of the coincidence stands in for the flag's clock pulse
  assign qual_pulse = halt_qualify_gate & ~s_r.coin_d;

  assign setup = psel & ~penable;
  assign wr_acc = psel & penable & pwrite;
  assign run_edge = (run_s & ~s_r.run_d)
    | (wr_acc && paddr == `FPHC_CTRL_OFS && pwdata[`FPHC_CTRL_SW_RUN]);
  assign step_edge = (step_s & ~s_r.step_d)
    | (wr_acc && paddr == `FPHC_CTRL_OFS && pwdata[`FPHC_CTRL_SW_STEP]);

  // stepping is only meaningful while halted
  assign step_set = s_r.halt & ~s_r.step
    & (step_edge | (slow_s & slow_tick));
  assign halt_set = qual_pulse & s_r.stage_b;

  assign ctrl_rd = {31'h0000_0000, s_r.fetch_en};
  always_comb begin
    status_rd = 32'h0000_0000;
    status_rd[`FPHC_ST_HALT] = s_r.halt;
    status_rd[`FPHC_ST_STEP] = s_r.step;
    status_rd[`FPHC_ST_READY] = panel_ready;
    status_rd[`FPHC_ST_STAGE_A] = s_r.stage_a;
    status_rd[`FPHC_ST_STAGE_B] = s_r.stage_b;
    status_rd[`FPHC_ST_SLOW] = slow_s;
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.coin_d = halt_qualify_gate;
    s_nxt.run_d = run_s;
    s_nxt.step_d = step_s;
    // stop level walks two stages on the slow panel clock
    if (panel_tick) begin
      s_nxt.stage_a = stop_s;
      s_nxt.stage_b = s_r.stage_a;
    end
    // set beats clear; once set only run releases it
    if (halt_set) begin
      s_nxt.halt = 1'b1;
    end else if (run_edge) begin
      s_nxt.halt = 1'b0;
    end
    if (step_set) begin
      s_nxt.step = 1'b1;
      s_nxt.steps = s_r.steps + 16'h0001;
    end else if (qual_pulse) begin
      s_nxt.step = 1'b0;
    end
    // the fetch jumper is a register bit; reset leaves it fitted
    if (wr_acc && paddr == `FPHC_CTRL_OFS) begin
      s_nxt.fetch_en = pwdata[`FPHC_CTRL_FETCH_EN];
    end
    // read data is captured in setup so it comes from a flop
    if (setup) begin
      s_nxt.pslverr = 1'b0;
      case (paddr)
        `FPHC_CTRL_OFS: s_nxt.prdata = ctrl_rd;
        `FPHC_STATUS_OFS: s_nxt.prdata = status_rd;
        `FPHC_STEPS_OFS: s_nxt.prdata = {16'h0000, s_r.steps};
        default: begin
          s_nxt.prdata = 32'h0000_0000;
          s_nxt.pslverr = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      s_r.fetch_en <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // zero wait states: read data is already held from the setup cycle
  assign pready = 1'b1;
  assign prdata = s_r.prdata;
  assign pslverr = s_r.pslverr;
  assign panel_ready = ~s_r.halt | s_r.step;
  assign run_n = s_r.halt;
  assign switch_enable_buffer_n = ~s_r.halt;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  halt_set_a: assert property (
    qual_pulse && s_r.stage_b |=> s_r.halt && run_n)
    else $error("halt not set by qualified stop");

  halt_entry_a: assert property (
    !s_r.halt ##1 s_r.halt |-> $past(halt_qualify_gate) && $past(sync_s))
    else $error("halt entered outside qualify window");

  halt_hold_a: assert property (
    s_r.halt && !run_edge |=> s_r.halt)
    else $error("halt dropped without run");

  ready_block_a: assert property (
    s_r.halt && !s_r.step |-> !panel_ready && run_n)
    else $error("ready high while halted");

  switch_en_a: assert property (
    $rose(s_r.halt) |-> !switch_enable_buffer_n)
    else $error("switch enable not low on halt");

  stage_walk_a: assert property (
    $rose(s_r.stage_b) |-> $past(s_r.stage_a) && $past(panel_tick))
    else $error("stop skipped a sync stage");

  step_grant_a: assert property (
    step_set |=> panel_ready ##0 s_r.step)
    else $error("step did not enable ready");

  step_end_a: assert property (
    s_r.step && qual_pulse && !step_set |=> !s_r.step)
    else $error("step not cleared by next instruction");

  fetch_gate_a: assert property (
    s_r.fetch_en && !fetch_s |-> !qual_pulse)
    else $error("qualify without fetch status");

  slow_step_a: assert property (
    slow_s && slow_tick && s_r.halt && !s_r.step |=> s_r.step)
    else $error("slow tick did not start a step");

  run_clear_a: assert property (
    run_edge && !halt_set |=> !s_r.halt ##0 panel_ready)
    else $error("run did not release halt");

  ready_run_a: assert property (
    !s_r.halt |-> panel_ready)
    else $error("ready low while running");

  run_level_a: assert property (
    $rose(run_n) && !s_r.step |-> !panel_ready)
    else $error("run disabled but ready high");

  stop_needed_a: assert property (
    !s_r.halt && !s_r.stage_b |=> !s_r.halt)
    else $error("halt without synchronized stop");

  pulse_only_a: assert property (
    !s_r.halt && !qual_pulse |=> !s_r.halt)
    else $error("halt outside qualify pulse");

  fetch_required_a: assert property (
    s_r.fetch_en && qual_pulse |-> fetch_s && sync_s && strobe_s)
    else $error("qualify without full coincidence");

  stage_hold_a: assert property (
    !panel_tick |=> $stable(s_r.stage_a) && $stable(s_r.stage_b))
    else $error("stop stage moved without panel tick");

  stage_shift_a: assert property (
    panel_tick |=> s_r.stage_b == $past(s_r.stage_a))
    else $error("second stage missed first stage");

  stage_load_a: assert property (
    panel_tick |=> s_r.stage_a == $past(stop_s))
    else $error("first stage missed stop level");

  qual_single_a: assert property (
    qual_pulse |=> !qual_pulse)
    else $error("qualify pulse longer than a cycle");

  halt_cause_a: assert property (
    $rose(s_r.halt) |-> $past(qual_pulse) && $past(s_r.stage_b))
    else $error("halt set without qualified stop");

  set_wins_a: assert property (
    halt_set |=> s_r.halt)
    else $error("run beat a qualified stop");

  switch_level_a: assert property (
    s_r.halt |-> !switch_enable_buffer_n)
    else $error("switches disabled while halted");

  halt_stays_a: assert property (
    s_r.halt && !stop_s && !run_edge |=> s_r.halt)
    else $error("halt lost after stop release");

  ready_gate_a: assert property (
    run_n && !s_r.step |-> !panel_ready)
    else $error("ready high with run disabled");

  strobe_invert_a: assert property (
    halt_qualify_gate |-> !pins_s[1] && pins_s[2])
    else $error("qualify without low strobe");

  step_ready_a: assert property (
    s_r.step |-> panel_ready)
    else $error("step active but ready low");

  step_needs_halt_a: assert property (
    $rose(s_r.step) |-> $past(s_r.halt))
    else $error("step started while running");

  step_count_a: assert property (
    $rose(s_r.step) |-> s_r.steps == $past(s_r.steps) + 16'h0001)
    else $error("step count not advanced");

  step_source_a: assert property (
    $rose(s_r.step) |-> $past(step_edge) || $past(slow_s && slow_tick))
    else $error("step without request");

  step_stays_a: assert property (
    s_r.step && !qual_pulse |=> s_r.step)
    else $error("step ended early");

  step_clear_a: assert property (
    $fell(s_r.step) |-> $past(qual_pulse))
    else $error("step cleared without qualify pulse");

  slow_off_a: assert property (
    !slow_s && !step_edge |=> !$rose(s_r.step))
    else $error("step started with slow off");

  jumper_cycle_a: assert property (
    !s_r.fetch_en && sync_s && strobe_s && !s_r.coin_d |-> qual_pulse)
    else $error("machine cycle not qualified");

  run_release_a: assert property (
    !s_r.halt |-> !run_n && switch_enable_buffer_n)
    else $error("outputs still halted after run");

  halt_seen_c: cover property ($rose(s_r.halt));
  step_done_c: cover property (s_r.step ##[1:200] !s_r.step);
  slow_seen_c: cover property (slow_s && slow_tick && s_r.halt);
  resume_c: cover property ($fell(s_r.halt));
  stop_walk_c: cover property ($rose(s_r.stage_b));
endmodule

// ---- logic/fphc_sync2.sv ----
`timescale 1ns/100ps
module fphc_sync2 #(
  parameter int WIDTH = 7
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] first_r;
  logic [WIDTH-1:0] second_r;

  if (WIDTH < 1) begin : g_bad_width
    $error("fphc_sync2 width must be at least 1");
  end

  // first stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_r <= '0;
      second_r <= '0;
    end else begin
      first_r <= async_in;
      second_r <= first_r;
    end
  end

  assign sync_out = second_r;
endmodule

// ---- tb/fphc_cpu_model.sv ----
`timescale 1ns/100ps
module fphc_cpu_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // ready from the panel
  input wire logic panel_ready,
  // status lines toward the panel
  output logic bus_cycle_sync,
  output logic status_latch_strobe_n,
  output logic fetch_status_bit
);
  // eight states a machine cycle, three machine cycles an instruction
  logic [2:0] ph_r;
  logic [1:0] mc_r;
  logic junk_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_r <= 3'h0;
      mc_r <= 2'h0;
      junk_r <= 1'b0;
    end else begin
      junk_r <= ~junk_r;
      // a new machine cycle starts only while ready is high
      if (ph_r != 3'h0 || panel_ready) begin
        ph_r <= ph_r + 3'h1;
        if (ph_r == 3'h7) begin
          mc_r <= (mc_r == 2'h2) ? 2'h0 : mc_r + 2'h1;
        end
      end
    end
  end
  assign bus_cycle_sync = (ph_r == 3'h1) || (ph_r == 3'h2);
  assign status_latch_strobe_n = (ph_r != 3'h2);
  // status is valid only during sync; otherwise the lines churn
  assign fetch_status_bit = bus_cycle_sync ? (mc_r == 2'h0) : junk_r;
endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/100ps
module testbench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic pready, pslverr, panel_ready, run_n, sw_en_n, err;
  logic [31:0] prdata, rd;
  logic stop_sw = 1'b0;
  logic run_sw = 1'b0;
  logic step_sw = 1'b0;
  logic slow_sw = 1'b0;
  logic sync, stb_n, fetch;
  int bad_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  int hi;

  always #2.5 pclk = ~pclk;

  fphc_run_halt #(.SLOW_CYCLES(50), .PANEL_CYCLES(4)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .stop_switch(stop_sw),
    .run_switch(run_sw), .step_switch(step_sw), .slow_switch(slow_sw),
    .bus_cycle_sync(sync), .status_latch_strobe_n(stb_n),
    .fetch_status_bit(fetch), .panel_ready(panel_ready), .run_n(run_n),
    .switch_enable_buffer_n(sw_en_n));

  fphc_cpu_model cpu (
    .pclk(pclk), .presetn(presetn), .panel_ready(panel_ready),
    .bus_cycle_sync(sync), .status_latch_strobe_n(stb_n),
    .fetch_status_bit(fetch));

  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // hangs are cut short here rather than by every wait loop
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      end_of_test();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // counts the cycles that ready stays up for one step
  task automatic do_step();
    @(posedge pclk);
    step_sw <= 1'b1;
    while (panel_ready !== 1'b1) @(posedge pclk);
    hi = 0;
    while (panel_ready === 1'b1) begin
      @(posedge pclk);
      hi++;
    end
    step_sw <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask

  task automatic t_stop();
    stop_sw <= 1'b1;
    while (run_n !== 1'b1) @(posedge pclk);
    check({31'h0, panel_ready}, 32'h0);
    check({31'h0, sw_en_n}, 32'h0);
    repeat (12) @(posedge pclk);
    check({30'h0, cpu.mc_r}, 32'h1);
    stop_sw <= 1'b0;
    repeat (40) @(posedge pclk);
    check({31'h0, run_n}, 32'h1);
    apb(1'b0, 12'h004, 32'h0);
    check(rd, 32'h1);
  endtask

  task automatic t_step();
    do_step();
    check({31'h0, hi > 12}, 32'h1);
    apb(1'b1, 12'h000, 32'h0);
    do_step();
    check({31'h0, hi <= 12}, 32'h1);
    apb(1'b0, 12'h008, 32'h0);
    check(rd, 32'h2);
    apb(1'b1, 12'h000, 32'h1);
    slow_sw <= 1'b1;
    repeat (2) begin
      while (panel_ready !== 1'b1) @(posedge pclk);
      apb(1'b0, 12'h004, 32'h0);
      check(rd, 32'h27);
      while (panel_ready === 1'b1) @(posedge pclk);
    end
    slow_sw <= 1'b0;
    repeat (80) @(posedge pclk);
    apb(1'b0, 12'h008, 32'h0);
    check(rd, 32'h4);
    check({31'h0, panel_ready}, 32'h0);
  endtask

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    check({29'h0, panel_ready, run_n, sw_en_n}, 32'h5);
    apb(1'b0, 12'h000, 32'h0);
    check(rd, 32'h1);
    apb(1'b0, 12'h004, 32'h0);
    check(rd, 32'h4);
    apb(1'b0, 12'h00C, 32'h0);
    check({rd[30:0], err}, 32'h1);
    t_stop();
    t_step();
    run_sw <= 1'b1;
    repeat (4) @(posedge pclk);
    check({29'h0, panel_ready, run_n, sw_en_n}, 32'h5);
    run_sw <= 1'b0;
    t_stop();
    apb(1'b1, 12'h000, 32'h5);
    @(posedge pclk);
    check({31'h0, panel_ready}, 32'h1);
    apb(1'b1, 12'h000, 32'h3);
    repeat (4) @(posedge pclk);
    check({29'h0, panel_ready, run_n, sw_en_n}, 32'h5);
    end_of_test();
  end
endmodule
